// ### rtl/acr_pkg.sv
package acr_pkg;
    // special-function register addresses
    localparam logic [7:0] ADDR_OFS_LOW = 8'hD1;
    localparam logic [7:0] ADDR_OFS_MID = 8'hD2;
    localparam logic [7:0] ADDR_OFS_HIGH = 8'hD3;
    localparam logic [7:0] ADDR_GAIN_LOW = 8'hD4;
    localparam logic [7:0] ADDR_GAIN_MID = 8'hD5;
    localparam logic [7:0] ADDR_GAIN_HIGH = 8'hD6;
    localparam logic [7:0] ADDR_CHAN_SEL = 8'hD7;
    localparam logic [7:0] ADDR_IRQ_CTRL = 8'hD8;
    localparam logic [7:0] ADDR_RES_LOW = 8'hD9;
    localparam logic [7:0] ADDR_RES_MID = 8'hDA;
    localparam logic [7:0] ADDR_RES_HIGH = 8'hDB;
    localparam logic [7:0] ADDR_ANA_CTRL = 8'hDC;
    // reset values and channel codes
    localparam logic [7:0] RST_OFS = 8'h00;
    localparam logic [7:0] RST_GAIN_LOW = 8'h5A;
    localparam logic [7:0] RST_GAIN_MID = 8'hEC;
    localparam logic [7:0] RST_GAIN_HIGH = 8'h5F;
    localparam logic [7:0] RST_CHAN_SEL = 8'h01;
    localparam logic [7:0] RST_IRQ_CTRL = 8'h40;
    localparam logic [7:0] RST_ANA_CTRL = 8'h30;
    localparam logic [7:0] RST_RESULT = 8'h00;
    localparam logic [7:0] CHAN_TEMP = 8'hFF;
    localparam logic [3:0] CHAN_COMMON = 4'h8;
    // interrupt control fields
    localparam int IC_BAUD_DBL = 7;
    localparam int IC_ONE = 6;
    localparam int IC_AUX_EN = 5;
    localparam int IC_AUX_FLAG = 4;
    localparam int IC_WD_FLAG = 3;
    // analog control fields
    localparam int AC_REF_SRC = 7;
    localparam int AC_OPEN_DET = 6;
    localparam int AC_REF_EN = 5;
    localparam int AC_REF_LVL = 4;
    localparam int AC_BUF_EN = 3;
    localparam int AC_GAIN_HI = 2;
    // reference clock: microsecond tick divided by four, core clock by four times (divider+1)
    localparam int REF_CLK_DIV = 4;
    localparam int REF_CLK_MAX_HZ = 250000;
    localparam int CORE_CLK_HZ = 125000000;
endpackage : acr_pkg

// ### rtl/acr_regbank.sv
// Functional notes
// - 24-bit offset correction in three bytes, reset zero, writes update it
// - 24-bit gain correction bytes reset 5Ah, ECh, 5Fh; writes replace them
// - upper channel nibble picks positive input 0-7 or common; reset 0
// - lower nibble picks negative input, same table; register resets 01h
// - temperature sensor selected only when channel register equals FFh
// - baud doubler bit set doubles serial port 1 rate; resets zero
// - auxiliary interrupt gated by enable bit, reset disabled
// - auxiliary flag set on event, stays set until software clears it
// - software setting auxiliary flag raises interrupt when enabled
// - watchdog flag sticky until cleared; software set raises interrupt if enabled
// - watchdog expiry interrupts only when reset action disabled, else resets
// - interrupt control resets 40h, bit 6 reads one, bits 2-0 zero
// - conversion result readable as three read-only bytes, reset zero
// - reading result low byte clears pending converter interrupt source
// - reference clock: core clock/(4*(divider+1)) or microsecond tick/4
// - open-input detect bit enables opposing burnout sources; resets zero
// - reference enable and level bits, both reset one: on, 2.5V
// - input buffer enable bit, resets zero
// - three-bit gain field selects gain of two to the field value
// - analog control resets 30h
`timescale 1ns/100ps
module acr_regbank #(
    parameter int RESULT_W = 24
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic [23:0] offset_cal,
    output logic [23:0] gain_cal,
    output logic [8:0] positive_channel_select,
    output logic [8:0] negative_channel_select,
    output logic temp_sensor_select,
    output logic uart1_baud_doubler,
    input wire logic aux_event,
    output logic aux_irq_req,
    input wire logic watchdog_expire,
    input wire logic watchdog_reset_action,
    input wire logic watchdog_irq_enable,
    output logic watchdog_irq_req,
    output logic watchdog_reset_req,
    input wire logic conv_done,
    input wire logic [23:0] conv_data,
    output logic adc_irq_pending,
    input wire logic [7:0] analog_divider,
    input wire logic microsecond_tick,
    output logic reference_clock_tick,
    output logic open_input_detect,
    output logic internal_reference_enable,
    output logic reference_level_select,
    output logic input_buffer_enable,
    output logic [2:0] gain_select,
    output logic [7:0] gain_factor
);
    if (RESULT_W != 24) begin : g_bad_width
        $error("acr_regbank serves a 24-bit result only");
    end

    typedef struct packed {
        logic [7:0] rdata;
        logic [7:0] chan;
        logic baud_dbl;
        logic aux_en;
        logic aux_flag;
        logic wd_flag;
        logic [23:0] result;
        logic adc_pend;
        logic [7:0] ana;
        logic [8:0] pos_oh;
        logic [8:0] neg_oh;
        logic temp_sel;
        logic aux_req;
        logic wd_req;
        logic wd_rst;
        logic [9:0] div_cnt;
        logic [1:0] us_tick_cnt;
        logic ref_tick;
        logic [7:0] gain_fac;
    } acr_state_s;

    acr_state_s st_ff;
    acr_state_s nxt_st;
    logic [7:0] ofs_low;
    logic [7:0] ofs_mid;
    logic [7:0] ofs_high;
    logic [7:0] gain_low;
    logic [7:0] gain_mid;
    logic [7:0] gain_high;
    logic [7:0] rd_mux;
    logic [7:0] irq_ctrl_rd;

    acr_sfr_byte #(.ADDR(acr_pkg::ADDR_OFS_LOW), .RST_VAL(acr_pkg::RST_OFS)) u_ofs_low (
        .core_clk(core_clk), .rst(rst), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .q(ofs_low));
    acr_sfr_byte #(.ADDR(acr_pkg::ADDR_OFS_MID), .RST_VAL(acr_pkg::RST_OFS)) u_ofs_mid (
        .core_clk(core_clk), .rst(rst), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .q(ofs_mid));
    acr_sfr_byte #(.ADDR(acr_pkg::ADDR_OFS_HIGH), .RST_VAL(acr_pkg::RST_OFS)) u_ofs_high (
        .core_clk(core_clk), .rst(rst), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .q(ofs_high));
    acr_sfr_byte #(.ADDR(acr_pkg::ADDR_GAIN_LOW), .RST_VAL(acr_pkg::RST_GAIN_LOW)) u_gain_low (
        .core_clk(core_clk), .rst(rst), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .q(gain_low));
    acr_sfr_byte #(.ADDR(acr_pkg::ADDR_GAIN_MID), .RST_VAL(acr_pkg::RST_GAIN_MID)) u_gain_mid (
        .core_clk(core_clk), .rst(rst), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .q(gain_mid));
    acr_sfr_byte #(.ADDR(acr_pkg::ADDR_GAIN_HIGH), .RST_VAL(acr_pkg::RST_GAIN_HIGH)) u_gain_high (
        .core_clk(core_clk), .rst(rst), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .q(gain_high));

    // codes 9..14 and the split temperature code select nothing
    function automatic logic [8:0] acr_chan_decode(input logic [3:0] code);
        logic [8:0] oh;
        oh = 9'h000;
        if (code <= acr_pkg::CHAN_COMMON) begin
            oh[code] = 1'b1;
        end
        return oh;
    endfunction : acr_chan_decode

    always_comb begin
        irq_ctrl_rd = 8'h00;
        irq_ctrl_rd[acr_pkg::IC_BAUD_DBL] = st_ff.baud_dbl;
        irq_ctrl_rd[acr_pkg::IC_ONE] = 1'b1;
        irq_ctrl_rd[acr_pkg::IC_AUX_EN] = st_ff.aux_en;
        irq_ctrl_rd[acr_pkg::IC_AUX_FLAG] = st_ff.aux_flag;
        irq_ctrl_rd[acr_pkg::IC_WD_FLAG] = st_ff.wd_flag;
        case (sfr_addr)
            acr_pkg::ADDR_OFS_LOW: rd_mux = ofs_low;
            acr_pkg::ADDR_OFS_MID: rd_mux = ofs_mid;
            acr_pkg::ADDR_OFS_HIGH: rd_mux = ofs_high;
            acr_pkg::ADDR_GAIN_LOW: rd_mux = gain_low;
            acr_pkg::ADDR_GAIN_MID: rd_mux = gain_mid;
            acr_pkg::ADDR_GAIN_HIGH: rd_mux = gain_high;
            acr_pkg::ADDR_CHAN_SEL: rd_mux = st_ff.chan;
            acr_pkg::ADDR_IRQ_CTRL: rd_mux = irq_ctrl_rd;
            acr_pkg::ADDR_RES_LOW: rd_mux = st_ff.result[7:0];
            acr_pkg::ADDR_RES_MID: rd_mux = st_ff.result[15:8];
            acr_pkg::ADDR_RES_HIGH: rd_mux = st_ff.result[23:16];
            acr_pkg::ADDR_ANA_CTRL: rd_mux = st_ff.ana;
            default: rd_mux = 8'h00;
        endcase
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.wd_rst = 1'b0;
        nxt_st.ref_tick = 1'b0;
        if (sfr_rd) begin
            nxt_st.rdata = rd_mux;
        end
        if (sfr_wr) begin
            case (sfr_addr)
                acr_pkg::ADDR_CHAN_SEL: nxt_st.chan = sfr_wdata;
                acr_pkg::ADDR_IRQ_CTRL: begin
                    nxt_st.baud_dbl = sfr_wdata[acr_pkg::IC_BAUD_DBL];
                    nxt_st.aux_en = sfr_wdata[acr_pkg::IC_AUX_EN];
                    nxt_st.aux_flag = sfr_wdata[acr_pkg::IC_AUX_FLAG];
                    nxt_st.wd_flag = sfr_wdata[acr_pkg::IC_WD_FLAG];
                end
                acr_pkg::ADDR_ANA_CTRL: nxt_st.ana = sfr_wdata;
                default: nxt_st.chan = st_ff.chan;
            endcase
        end
        // hardware set wins over a software clear in the same cycle
        if (aux_event) begin
            nxt_st.aux_flag = 1'b1;
        end
        if (watchdog_expire) begin
            if (watchdog_reset_action) begin
                nxt_st.wd_rst = 1'b1;
            end else begin
                nxt_st.wd_flag = 1'b1;
            end
        end
        if (sfr_rd && sfr_addr == acr_pkg::ADDR_RES_LOW) begin
            nxt_st.adc_pend = 1'b0;
        end
        if (conv_done) begin
            nxt_st.result = conv_data;
            nxt_st.adc_pend = 1'b1;
        end
        // requests follow the flags, so a still-set flag keeps requesting
        nxt_st.aux_req = nxt_st.aux_flag && nxt_st.aux_en;
        nxt_st.wd_req = nxt_st.wd_flag && watchdog_irq_enable;
        nxt_st.temp_sel = (nxt_st.chan == acr_pkg::CHAN_TEMP);
        nxt_st.pos_oh = acr_chan_decode(nxt_st.chan[7:4]);
        nxt_st.neg_oh = acr_chan_decode(nxt_st.chan[3:0]);
        nxt_st.gain_fac = 8'h01 << nxt_st.ana[acr_pkg::AC_GAIN_HI:0];
        // both counters restart on each tick, so ticks are at least four cycles apart
        if (st_ff.ana[acr_pkg::AC_REF_SRC]) begin
            if (microsecond_tick) begin
                nxt_st.us_tick_cnt = st_ff.us_tick_cnt + 2'd1;
                if (st_ff.us_tick_cnt == 2'(acr_pkg::REF_CLK_DIV - 1)) begin
                    nxt_st.ref_tick = 1'b1;
                end
            end
        end else begin
            nxt_st.div_cnt = st_ff.div_cnt + 10'd1;
            if (st_ff.div_cnt >= {analog_divider, 2'b11}) begin
                nxt_st.ref_tick = 1'b1;
            end
        end
        if (nxt_st.ref_tick) begin
            nxt_st.div_cnt = 10'd0;
            nxt_st.us_tick_cnt = 2'd0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_ff <= '{
                rdata: 8'h00,
                chan: acr_pkg::RST_CHAN_SEL,
                baud_dbl: acr_pkg::RST_IRQ_CTRL[acr_pkg::IC_BAUD_DBL],
                aux_en: acr_pkg::RST_IRQ_CTRL[acr_pkg::IC_AUX_EN],
                aux_flag: acr_pkg::RST_IRQ_CTRL[acr_pkg::IC_AUX_FLAG],
                wd_flag: acr_pkg::RST_IRQ_CTRL[acr_pkg::IC_WD_FLAG],
                result: {3{acr_pkg::RST_RESULT}},
                adc_pend: 1'b0,
                ana: acr_pkg::RST_ANA_CTRL,
                pos_oh: 9'h001,
                neg_oh: 9'h002,
                temp_sel: 1'b0,
                aux_req: 1'b0,
                wd_req: 1'b0,
                wd_rst: 1'b0,
                div_cnt: 10'd0,
                us_tick_cnt: 2'd0,
                ref_tick: 1'b0,
                gain_fac: 8'h01
            };
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sfr_rdata = st_ff.rdata;
    assign offset_cal = {ofs_high, ofs_mid, ofs_low};
    assign gain_cal = {gain_high, gain_mid, gain_low};
    assign positive_channel_select = st_ff.pos_oh;
    assign negative_channel_select = st_ff.neg_oh;
    assign temp_sensor_select = st_ff.temp_sel;
    assign uart1_baud_doubler = st_ff.baud_dbl;
    assign aux_irq_req = st_ff.aux_req;
    assign watchdog_irq_req = st_ff.wd_req;
    assign watchdog_reset_req = st_ff.wd_rst;
    assign adc_irq_pending = st_ff.adc_pend;
    assign reference_clock_tick = st_ff.ref_tick;
    assign open_input_detect = st_ff.ana[acr_pkg::AC_OPEN_DET];
    assign internal_reference_enable = st_ff.ana[acr_pkg::AC_REF_EN];
    assign reference_level_select = st_ff.ana[acr_pkg::AC_REF_LVL];
    assign input_buffer_enable = st_ff.ana[acr_pkg::AC_BUF_EN];
    assign gain_select = st_ff.ana[acr_pkg::AC_GAIN_HI:0];
    assign gain_factor = st_ff.gain_fac;

    chk_ofs_write: assert property (@(posedge core_clk) disable iff (rst)
        sfr_wr && sfr_addr == acr_pkg::ADDR_OFS_MID |=> offset_cal[15:8] == $past(sfr_wdata))
        else $error("offset middle byte not written");

    chk_gain_write: assert property (@(posedge core_clk) disable iff (rst)
        sfr_wr && sfr_addr == acr_pkg::ADDR_GAIN_HIGH |=> gain_cal[23:16] == $past(sfr_wdata))
        else $error("gain high byte not written");

    chk_pos_common: assert property (@(posedge core_clk) disable iff (rst)
        st_ff.chan[7:4] == acr_pkg::CHAN_COMMON |-> positive_channel_select == 9'h100)
        else $error("common positive code not decoded");

    chk_neg_common: assert property (@(posedge core_clk) disable iff (rst)
        st_ff.chan[3:0] == acr_pkg::CHAN_COMMON |-> negative_channel_select == 9'h100)
        else $error("common negative code not decoded");

    chk_temp_route: assert property (@(posedge core_clk) disable iff (rst)
        temp_sensor_select |-> positive_channel_select == 9'h000 && negative_channel_select == 9'h000)
        else $error("temperature sensor routed with an input selected");

    chk_baud_write: assert property (@(posedge core_clk) disable iff (rst)
        sfr_wr && sfr_addr == acr_pkg::ADDR_IRQ_CTRL
        |=> uart1_baud_doubler == $past(sfr_wdata[acr_pkg::IC_BAUD_DBL]))
        else $error("baud doubler bit not written");

    chk_aux_set: assert property (@(posedge core_clk) disable iff (rst)
        aux_event |=> st_ff.aux_flag)
        else $error("auxiliary event did not set flag");

    chk_aux_sticky: assert property (@(posedge core_clk) disable iff (rst)
        st_ff.aux_flag && !(sfr_wr && sfr_addr == acr_pkg::ADDR_IRQ_CTRL) |=> st_ff.aux_flag)
        else $error("auxiliary flag dropped without a write");

    chk_aux_gate: assert property (@(posedge core_clk) disable iff (rst)
        sfr_wr && sfr_addr == acr_pkg::ADDR_IRQ_CTRL && sfr_wdata[5:4] == 2'b11
        |=> aux_irq_req ##1 (aux_irq_req || $past(sfr_wr)))
        else $error("software auxiliary set did not request");

    chk_wd_route: assert property (@(posedge core_clk) disable iff (rst)
        watchdog_expire && watchdog_reset_action |=> watchdog_reset_req ##1 !watchdog_reset_req)
        else $error("watchdog reset request not one cycle");

    chk_wd_flag: assert property (@(posedge core_clk) disable iff (rst)
        watchdog_expire && !watchdog_reset_action |=> st_ff.wd_flag && !watchdog_reset_req)
        else $error("watchdog expiry did not set flag");

    chk_wd_sticky: assert property (@(posedge core_clk) disable iff (rst)
        st_ff.wd_flag && !(sfr_wr && sfr_addr == acr_pkg::ADDR_IRQ_CTRL) |=> st_ff.wd_flag)
        else $error("watchdog flag dropped without a write");

    chk_ctrl_read: assert property (@(posedge core_clk) disable iff (rst)
        sfr_rd && sfr_addr == acr_pkg::ADDR_IRQ_CTRL |=> sfr_rdata[6] && sfr_rdata[2:0] == 3'b000)
        else $error("interrupt control fixed bits wrong");

    chk_res_ro: assert property (@(posedge core_clk) disable iff (rst)
        sfr_wr && sfr_addr == acr_pkg::ADDR_RES_LOW && !conv_done |=> $stable(st_ff.result))
        else $error("result byte changed by a write");

    chk_res_load: assert property (@(posedge core_clk) disable iff (rst)
        conv_done |=> st_ff.result == $past(conv_data) && adc_irq_pending)
        else $error("result not loaded with pending source");

    chk_res_clear: assert property (@(posedge core_clk) disable iff (rst)
        sfr_rd && sfr_addr == acr_pkg::ADDR_RES_LOW && !conv_done |=> !adc_irq_pending)
        else $error("low result read did not clear pending");

    chk_pend_hold: assert property (@(posedge core_clk) disable iff (rst)
        adc_irq_pending && !(sfr_rd && sfr_addr == acr_pkg::ADDR_RES_LOW) |=> adc_irq_pending)
        else $error("pending source dropped without a low read");

    chk_ref_space: assert property (@(posedge core_clk) disable iff (rst)
        reference_clock_tick |=> (!reference_clock_tick)[*3])
        else $error("reference ticks closer than four cycles");

    chk_open_det: assert property (@(posedge core_clk) disable iff (rst)
        sfr_wr && sfr_addr == acr_pkg::ADDR_ANA_CTRL
        |=> open_input_detect == $past(sfr_wdata[acr_pkg::AC_OPEN_DET]))
        else $error("open input detect bit not written");

    chk_ref_bits: assert property (@(posedge core_clk) disable iff (rst)
        sfr_wr && sfr_addr == acr_pkg::ADDR_ANA_CTRL
        |=> {internal_reference_enable, reference_level_select}
            == $past(sfr_wdata[acr_pkg::AC_REF_EN:acr_pkg::AC_REF_LVL]))
        else $error("reference bits not written");

    chk_buf_en: assert property (@(posedge core_clk) disable iff (rst)
        sfr_wr && sfr_addr == acr_pkg::ADDR_ANA_CTRL
        |=> input_buffer_enable == $past(sfr_wdata[acr_pkg::AC_BUF_EN]))
        else $error("buffer enable bit not written");

    chk_gain_one: assert property (@(posedge core_clk) disable iff (rst)
        gain_select == 3'h0 |-> gain_factor == 8'h01)
        else $error("gain code zero not unity");

    chk_gain_code: assert property (@(posedge core_clk) disable iff (rst)
        gain_select == 3'd7 |-> gain_factor == 8'h80)
        else $error("gain code seven not 128");
endmodule : acr_regbank

// ### rtl/acr_sfr_byte.sv
`timescale 1ns/100ps
module acr_sfr_byte #(
    parameter logic [7:0] ADDR = 8'h00,
    parameter logic [7:0] RST_VAL = 8'h00
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] q
);
    typedef struct packed {
        logic [7:0] val;
    } acr_byte_s;

    acr_byte_s st_ff;
    acr_byte_s nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (sfr_wr && sfr_addr == ADDR) begin
            nxt_st.val = sfr_wdata;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_ff <= '{val: RST_VAL};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.val;
endmodule : acr_sfr_byte

// ### testbench/adc_control_register_bank_test.sv
`timescale 1ns/100ps
module adc_control_register_bank_test;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic aux_event = 1'b0;
    logic watchdog_expire = 1'b0;
    logic watchdog_reset_action = 1'b0;
    logic watchdog_irq_enable = 1'b1;
    logic conv_done = 1'b0;
    logic [23:0] conv_data = 24'h00_0000;
    logic [7:0] analog_divider = 8'h00;
    logic microsecond_tick = 1'b0;
    logic [7:0] sfr_rdata;
    logic [23:0] offset_cal;
    logic [23:0] gain_cal;
    logic [8:0] pos_sel;
    logic [8:0] neg_sel;
    logic temp_sel, baud_dbl, aux_req, wd_req, wd_rst, pending, ref_tick;
    logic open_det, ref_en, ref_lvl, buf_en;
    logic [2:0] gain_select;
    logic [7:0] gain_factor;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    int us_cnt = 0;
    logic us_en = 1'b0;

    acr_regbank acr_regbank_i (.core_clk(core_clk), .rst(rst), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .offset_cal(offset_cal), .gain_cal(gain_cal), .positive_channel_select(pos_sel),
        .negative_channel_select(neg_sel), .temp_sensor_select(temp_sel),
        .uart1_baud_doubler(baud_dbl), .aux_event(aux_event), .aux_irq_req(aux_req),
        .watchdog_expire(watchdog_expire), .watchdog_reset_action(watchdog_reset_action),
        .watchdog_irq_enable(watchdog_irq_enable), .watchdog_irq_req(wd_req),
        .watchdog_reset_req(wd_rst), .conv_done(conv_done), .conv_data(conv_data),
        .adc_irq_pending(pending), .analog_divider(analog_divider),
        .microsecond_tick(microsecond_tick), .reference_clock_tick(ref_tick),
        .open_input_detect(open_det), .internal_reference_enable(ref_en),
        .reference_level_select(ref_lvl), .input_buffer_enable(buf_en),
        .gain_select(gain_select), .gain_factor(gain_factor));

    always #4 core_clk = ~core_clk;

    // tick every fifth cycle so the divide-by-four source is easy to tell apart
    always @(posedge core_clk) begin
        #1;
        microsecond_tick = us_en && (us_cnt == 4);
        us_cnt = (us_cnt == 4) ? 0 : us_cnt + 1;
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 6000) begin
            err_total++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step

    // strobe drops a cycle before the next access so no signal changes twice at once
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        step(1);
        sfr_wr = 1'b0;
        step(1);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        sfr_addr = a;
        sfr_rd = 1'b1;
        step(1);
        sfr_rd = 1'b0;
        chk({16'h0000, sfr_rdata}, {16'h0000, exp}, what);
        step(1);
    endtask : rd

    task automatic t_reset();
        logic [7:0] rv [12] = '{8'h00, 8'h00, 8'h00, 8'h5A, 8'hEC, 8'h5F, 8'h01, 8'h40,
                                8'h00, 8'h00, 8'h00, 8'h30};
        chk(offset_cal, 24'h00_0000, "offset reset");
        chk(gain_cal, 24'h5F_EC5A, "gain reset");
        chk({15'h0000, pos_sel}, 24'h00_0001, "pos reset");
        chk({15'h0000, neg_sel}, 24'h00_0002, "neg reset");
        chk({21'h00_0000, baud_dbl, aux_req, temp_sel}, 24'h00_0000, "irq reset");
        chk({17'h0_0000, open_det, ref_en, ref_lvl, buf_en, gain_select}, 24'h00_0030,
            "ana reset");
        for (int i = 0; i < 12; i++) begin
            rd(8'hD1 + 8'(i), rv[i], "reset read");
        end
    endtask : t_reset

    task automatic t_cal();
        wr(8'hD1, 8'h11);
        wr(8'hD2, 8'h22);
        wr(8'hD3, 8'h33);
        chk(offset_cal, 24'h33_2211, "offset word");
        rd(8'hD2, 8'h22, "offset mid");
        wr(8'hD4, 8'hA1);
        wr(8'hD5, 8'hB2);
        wr(8'hD6, 8'hC3);
        chk(gain_cal, 24'hC3_B2A1, "gain word");
        rd(8'hD6, 8'hC3, "gain high");
    endtask : t_cal

    task automatic t_chan();
        for (int i = 0; i < 9; i++) begin
            wr(8'hD7, {4'(i), 4'(8 - i)});
            chk({15'h0000, pos_sel}, 24'(1 << i), "pos code");
            chk({15'h0000, neg_sel}, 24'(1 << (8 - i)), "neg code");
            chk({23'h00_0000, temp_sel}, 24'h00_0000, "no temp");
        end
        wr(8'hD7, 8'hFF);
        chk({23'h00_0000, temp_sel}, 24'h00_0001, "temp on");
        wr(8'hD7, 8'hF0);
        chk({23'h00_0000, temp_sel}, 24'h00_0000, "temp half");
    endtask : t_chan

    task automatic t_irq();
        int n;
        wr(8'hD8, 8'h80);
        chk({23'h00_0000, baud_dbl}, 24'h00_0001, "baud dbl");
        rd(8'hD8, 8'hC0, "ctrl fixed bits");
        wr(8'hD8, 8'hFF);
        rd(8'hD8, 8'hF8, "ctrl all set");
        chk({22'h00_0000, aux_req, wd_req}, 24'h00_0003, "sw set flags");
        wr(8'hD8, 8'h20);
        chk({22'h00_0000, aux_req, wd_req}, 24'h00_0000, "flags cleared");
        aux_event = 1'b1;
        step(1);
        aux_event = 1'b0;
        step(4);
        chk({23'h00_0000, aux_req}, 24'h00_0001, "aux sticky");
        rd(8'hD8, 8'h70, "aux flag");
        wr(8'hD8, 8'h10);
        chk({23'h00_0000, aux_req}, 24'h00_0000, "aux gated");
        wr(8'hD8, 8'h00);
        for (int a = 1; a >= 0; a--) begin
            watchdog_reset_action = a[0];
            watchdog_expire = 1'b1;
            step(1);
            watchdog_expire = 1'b0;
            n = int'(wd_rst);
            repeat (3) begin
                step(1);
                n += int'(wd_rst);
            end
            chk(24'(n), 24'(a), "reset pulses");
            chk({23'h00_0000, wd_req}, 24'(1 - a), "wd irq");
        end
        rd(8'hD8, 8'h48, "wd flag");
        watchdog_irq_enable = 1'b0;
        step(2);
        chk({23'h00_0000, wd_req}, 24'h00_0000, "wd disabled");
        watchdog_irq_enable = 1'b1;
        wr(8'hD8, 8'h00);
        chk({23'h00_0000, wd_req}, 24'h00_0000, "wd cleared");
    endtask : t_irq

    task automatic t_conv();
        conv_data = 24'hA5_B6C7;
        conv_done = 1'b1;
        step(1);
        conv_done = 1'b0;
        conv_data = 24'h12_3456;
        step(1);
        chk({23'h00_0000, pending}, 24'h00_0001, "pending set");
        rd(8'hDB, 8'hA5, "res high");
        rd(8'hDA, 8'hB6, "res mid");
        chk({23'h00_0000, pending}, 24'h00_0001, "pending held");
        wr(8'hD9, 8'h00);
        rd(8'hD9, 8'hC7, "res low ro");
        chk({23'h00_0000, pending}, 24'h00_0000, "pending cleared");
    endtask : t_conv

    task automatic t_analog();
        wr(8'hDC, 8'hC8);
        chk({20'h0_0000, open_det, ref_en, ref_lvl, buf_en}, 24'h9, "ana bits");
        wr(8'hDD, 8'hFF);
        rd(8'hDD, 8'h00, "unmapped");
        rd(8'hDC, 8'hC8, "ana read");
        for (int g = 0; g < 8; g++) begin
            wr(8'hDC, {5'b00110, 3'(g)});
            chk({12'h000, ref_lvl, gain_select, gain_factor},
                {12'h001, 3'(g), 8'(1 << g)}, "gain");
        end
    endtask : t_analog

    task automatic period(input int exp, input string what);
        int k;
        int n;
        k = 0;
        n = 0;
        while (ref_tick !== 1'b1 && k < 200) begin
            step(1);
            k++;
        end
        do begin
            step(1);
            n++;
        end while (ref_tick !== 1'b1 && n < 200);
        chk(24'(n), 24'(exp), what);
    endtask : period

    task automatic t_ref_clock();
        analog_divider = 8'h01;
        wr(8'hDC, 8'h30);
        period(8, "div 1");
        analog_divider = 8'h03;
        period(16, "div 3");
        us_en = 1'b1;
        wr(8'hDC, 8'hB0);
        period(20, "tick src");
        us_en = 1'b0;
    endtask : t_ref_clock

    initial begin
        repeat (6) @(posedge core_clk);
        #1;
        rst = 1'b0;
        t_reset();
        t_cal();
        t_chan();
        t_irq();
        t_conv();
        t_analog();
        t_ref_clock();
        print_verdict();
    end
endmodule : adc_control_register_bank_test
